// ### pkg/tsc_defines.svh
// Purpose: constants of the trigger and status controller
// Assumes: 10 MHz pclk, APB register access
// Notes:   times stay in their own unit, cycle counts derive from them
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define TSC_CLK_MHZ      10
`define TSC_HOLD_S       10
`define TSC_PURPLE_S     5
`define TSC_CYC_PER_S    1000000
`define TSC_EXPO_US_0    100
`define TSC_EXPO_US_1    200
`define TSC_EXPO_US_2    300
`define TSC_EXPO_US_3    400
`define TSC_BLINK_LAST   3'h3

// --------------------------------------------------------------
// register map
// --------------------------------------------------------------
`define TSC_OFF_CTRL     12'h000
`define TSC_OFF_IPADDR   12'h004
`define TSC_OFF_BLINK    12'h008
`define TSC_OFF_STATUS   12'h00C
`define TSC_CTRL_SLAVE   0
`define TSC_CTRL_FALL    1
`define TSC_CTRL_RANGE   3:2
`define TSC_CTRL_PSTATE  5:4
`define TSC_CTRL_MASK    32'h0000003F
`define TSC_CTRL_RST     32'h00000000
`define TSC_IP_DEFAULT   32'hC0A80165
`define TSC_BLINK_RST    24'h07A120
`define TSC_ST_EXPO      16
`define TSC_ST_RSTATE    19:17

`endif

// ### pkg/tsc_pkg.sv
// Purpose: types of the trigger and status controller
// Assumes: nothing
// Notes:   encodings written out
package tsc_pkg;
	typedef enum logic [1:0] {
		PS_BCAST = 2'b00,
		PS_CONN  = 2'b01,
		PS_DRV   = 2'b10,
		PS_FW    = 2'b11
	} tsc_pstate_t;

	typedef enum logic [2:0] {
		RS_IDLE   = 3'b000,
		RS_WAIT   = 3'b001,
		RS_PURPLE = 3'b010,
		RS_BLINK  = 3'b011,
		RS_RST    = 3'b100
	} tsc_rstate_t;
endpackage

// ### rtl/tsc_top.sv
// Purpose: frame trigger, address restore and status lamp control
// Assumes: inputs asynchronous to pclk are double-flopped, APB inputs are used directly
// Notes:   APB slave answers in the first access cycle
`timescale 1ns/1ns
`include "tsc_defines.svh"

module tsc_top #(
	parameter logic [26:0] HOLD_CYC   =
		27'(`TSC_HOLD_S * `TSC_CLK_MHZ * `TSC_CYC_PER_S),
	parameter logic [26:0] PURPLE_CYC =
		27'(`TSC_PURPLE_S * `TSC_CLK_MHZ * `TSC_CYC_PER_S)
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        frame_trigger,
	input  wire logic        address_restore_input,
	input  wire logic        restore_button,
	output logic             acq_start,
	output logic             exposure_active,
	output logic [31:0]      net_address,
	output logic             lamp_red,
	output logic             lamp_green,
	output logic             lamp_blue,
	output logic             self_reset
);
	import tsc_pkg::*;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [11:0] expo_cycles(input logic [1:0] m);
		case (m)
			2'h0:    expo_cycles = 12'(`TSC_EXPO_US_0 * `TSC_CLK_MHZ);
			2'h1:    expo_cycles = 12'(`TSC_EXPO_US_1 * `TSC_CLK_MHZ);
			2'h2:    expo_cycles = 12'(`TSC_EXPO_US_2 * `TSC_CLK_MHZ);
			default: expo_cycles = 12'(`TSC_EXPO_US_3 * `TSC_CLK_MHZ);
		endcase
	endfunction

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == `TSC_OFF_CTRL) || (a == `TSC_OFF_IPADDR) ||
			(a == `TSC_OFF_BLINK) || (a == `TSC_OFF_STATUS);
	endfunction

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	logic        trig_s1_reg, trig_s2_reg, trig_prev_reg;
	logic        rin_s1_reg, rin_s2_reg, btn_s1_reg, btn_s2_reg;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] ip_reg, ip_next;
	logic [23:0] blink_reg, blink_next;
	logic        pready_reg, pready_next;
	logic [31:0] prdata_reg, prdata_next;
	logic        pslverr_reg, pslverr_next;
	logic        acq_reg, acq_next;
	logic        expo_reg, expo_next;
	logic [11:0] expo_cnt_reg, expo_cnt_next;
	logic [15:0] frame_cnt_reg, frame_cnt_next;
	logic [23:0] tick_cnt_reg, tick_cnt_next;
	logic        phase_reg, phase_next;
	logic        tick;
	tsc_rstate_t rs_reg, rs_next;
	logic [26:0] hold_cnt_reg, hold_cnt_next;
	logic [2:0]  bl_cnt_reg, bl_cnt_next;
	logic        sreset_reg, sreset_next;
	logic        red_reg, red_next, green_reg, green_next;
	logic        blue_reg, blue_next;
	logic        trig_edge, accept, hold_active, wr_en, ip_restore;
	tsc_pstate_t pstate;

	assign pready          = pready_reg;
	assign prdata          = prdata_reg;
	assign pslverr         = pslverr_reg;
	assign acq_start       = acq_reg;
	assign exposure_active = expo_reg;
	assign net_address     = ip_reg;
	assign lamp_red        = red_reg;
	assign lamp_green      = green_reg;
	assign lamp_blue       = blue_reg;
	assign self_reset      = sreset_reg;
	assign pstate          = tsc_pstate_t'(ctrl_reg[`TSC_CTRL_PSTATE]);

	// --------------------------------------------------------------
	// input synchronisers
	// --------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_s1_reg   <= 1'b0;
			trig_s2_reg   <= 1'b0;
			trig_prev_reg <= 1'b0;
			rin_s1_reg    <= 1'b0;
			rin_s2_reg    <= 1'b0;
			btn_s1_reg    <= 1'b0;
			btn_s2_reg    <= 1'b0;
		end else begin
			trig_s1_reg   <= frame_trigger;
			trig_s2_reg   <= trig_s1_reg;
			trig_prev_reg <= trig_s2_reg;
			rin_s1_reg    <= address_restore_input;
			rin_s2_reg    <= rin_s1_reg;
			btn_s1_reg    <= restore_button;
			btn_s2_reg    <= btn_s1_reg;
		end
	end

	// --------------------------------------------------------------
	// apb slave and registers
	// --------------------------------------------------------------
	assign wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
	assign ip_restore = (rs_reg == RS_IDLE) && hold_active &&
		(hold_cnt_reg == HOLD_CYC - 27'h1);

	always_comb begin
		pready_next  = psel && !penable;
		pslverr_next = psel && !penable && !mapped(paddr);
		prdata_next  = prdata_reg;
		ctrl_next    = ctrl_reg;
		ip_next      = ip_reg;
		blink_next   = blink_reg;
		if (psel && !penable) begin
			prdata_next = 32'h00000000;
			case (paddr)
				`TSC_OFF_CTRL:   prdata_next = ctrl_reg;
				`TSC_OFF_IPADDR: prdata_next = ip_reg;
				`TSC_OFF_BLINK:  prdata_next = {8'h00, blink_reg};
				`TSC_OFF_STATUS: begin
					prdata_next[15:0]           = frame_cnt_reg;
					prdata_next[`TSC_ST_EXPO]   = expo_reg;
					prdata_next[`TSC_ST_RSTATE] = rs_reg;
				end
				default:         prdata_next = 32'h00000000;
			endcase
		end
		if (wr_en) begin
			case (paddr)
				`TSC_OFF_CTRL:   ctrl_next = pwdata & `TSC_CTRL_MASK;
				`TSC_OFF_IPADDR: ip_next = pwdata;
				`TSC_OFF_BLINK:  blink_next = pwdata[23:0];
				default:         ctrl_next = ctrl_reg;
			endcase
		end
		// a restore beats a software write in the same cycle
		if (ip_restore)
			ip_next = `TSC_IP_DEFAULT;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h00000000;
			ctrl_reg    <= `TSC_CTRL_RST;
			ip_reg      <= `TSC_IP_DEFAULT;
			blink_reg   <= `TSC_BLINK_RST;
		end else begin
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
			prdata_reg  <= prdata_next;
			ctrl_reg    <= ctrl_next;
			ip_reg      <= ip_next;
			blink_reg   <= blink_next;
		end
	end

	// --------------------------------------------------------------
	// frame trigger and exposure
	// --------------------------------------------------------------
	// edges during an exposure are dropped: one trigger, one frame
	assign trig_edge = ctrl_reg[`TSC_CTRL_FALL] ?
		(trig_prev_reg && !trig_s2_reg) :
		(!trig_prev_reg && trig_s2_reg);
	assign accept = ctrl_reg[`TSC_CTRL_SLAVE] && trig_edge && !expo_reg;

	always_comb begin
		acq_next       = 1'b0;
		expo_next      = expo_reg;
		expo_cnt_next  = expo_cnt_reg;
		frame_cnt_next = frame_cnt_reg;
		if (accept) begin
			acq_next       = 1'b1;
			expo_next      = 1'b1;
			expo_cnt_next  = expo_cycles(ctrl_reg[`TSC_CTRL_RANGE]);
			frame_cnt_next = frame_cnt_reg + 16'h0001;
		end else if (expo_reg) begin
			expo_cnt_next = expo_cnt_reg - 12'h001;
			if (expo_cnt_reg == 12'h001)
				expo_next = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acq_reg       <= 1'b0;
			expo_reg      <= 1'b0;
			expo_cnt_reg  <= 12'h000;
			frame_cnt_reg <= 16'h0000;
		end else begin
			acq_reg       <= acq_next;
			expo_reg      <= expo_next;
			expo_cnt_reg  <= expo_cnt_next;
			frame_cnt_reg <= frame_cnt_next;
		end
	end

	// --------------------------------------------------------------
	// blink tick
	// --------------------------------------------------------------
	assign tick = (tick_cnt_reg >= blink_reg);

	always_comb begin
		tick_cnt_next = tick ? 24'h000000 : tick_cnt_reg + 24'h000001;
		phase_next    = tick ? !phase_reg : phase_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_reg <= 24'h000000;
			phase_reg    <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			phase_reg    <= phase_next;
		end
	end

	// --------------------------------------------------------------
	// address restore sequence
	// --------------------------------------------------------------
	assign hold_active = rin_s2_reg || btn_s2_reg;

	always_comb begin
		rs_next       = rs_reg;
		hold_cnt_next = hold_cnt_reg;
		bl_cnt_next   = bl_cnt_reg;
		sreset_next   = 1'b0;
		case (rs_reg)
			RS_IDLE: begin
				hold_cnt_next = hold_active ? hold_cnt_reg + 27'h1 : 27'h0;
				if (ip_restore) begin
					rs_next       = RS_WAIT;
					hold_cnt_next = 27'h0;
				end
			end
			RS_WAIT: begin
				if (!hold_active)
					rs_next = RS_PURPLE;
			end
			RS_PURPLE: begin
				hold_cnt_next = hold_cnt_reg + 27'h1;
				if (hold_cnt_reg == PURPLE_CYC - 27'h1) begin
					rs_next     = RS_BLINK;
					bl_cnt_next = 3'h0;
				end
			end
			RS_BLINK: begin
				if (tick) begin
					bl_cnt_next = bl_cnt_reg + 3'h1;
					if (bl_cnt_reg == `TSC_BLINK_LAST)
						rs_next = RS_RST;
				end
			end
			RS_RST: begin
				sreset_next   = 1'b1;
				hold_cnt_next = 27'h0;
				rs_next       = RS_IDLE;
			end
			default: rs_next = RS_IDLE;
		endcase
	end

	// --------------------------------------------------------------
	// lamp
	// --------------------------------------------------------------
	always_comb begin
		red_next   = 1'b0;
		green_next = 1'b0;
		blue_next  = 1'b0;
		case (rs_reg)
			RS_WAIT:   blue_next = 1'b0;
			RS_PURPLE: begin
				red_next  = 1'b1;
				blue_next = 1'b1;
			end
			RS_BLINK: begin
				// starts dark so both flashes stand apart from purple
				red_next  = bl_cnt_reg[0];
				blue_next = bl_cnt_reg[0];
			end
			RS_RST:    blue_next = 1'b0;
			default: begin
				case (pstate)
					PS_CONN:  blue_next = 1'b1;
					PS_DRV:   green_next = phase_reg;
					PS_FW: begin
						red_next   = 1'b1;
						green_next = 1'b1;
						blue_next  = 1'b1;
					end
					default:  blue_next = phase_reg;
				endcase
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_reg       <= RS_IDLE;
			hold_cnt_reg <= 27'h0;
			bl_cnt_reg   <= 3'h0;
			sreset_reg   <= 1'b0;
			red_reg      <= 1'b0;
			green_reg    <= 1'b0;
			blue_reg     <= 1'b0;
		end else begin
			rs_reg       <= rs_next;
			hold_cnt_reg <= hold_cnt_next;
			bl_cnt_reg   <= bl_cnt_next;
			sreset_reg   <= sreset_next;
			red_reg      <= red_next;
			green_reg    <= green_next;
			blue_reg     <= blue_next;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence trig_taken;
		accept ##1 (acq_start && exposure_active);
	endsequence
	// cycles the exposure has stood so far; a counter stands in for a
	// long delay range, which the property tools would have to unroll
	logic [11:0] expo_len_reg, expo_len_next;
	always_comb
		expo_len_next = exposure_active ? expo_len_reg + 12'h001 : 12'h000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			expo_len_reg <= 12'h000;
		else
			expo_len_reg <= expo_len_next;
	end

	master_gate_a: assert property (
		!ctrl_reg[`TSC_CTRL_SLAVE] |=> !acq_start)
		else $error("frame started outside slave mode");
	edge_start_a: assert property (
		accept |-> trig_taken)
		else $error("accepted edge did not start a frame");
	rise_edge_a: assert property (
		acq_start && !ctrl_reg[`TSC_CTRL_FALL] |->
		$past(trig_s2_reg) && !$past(trig_prev_reg))
		else $error("frame start without rising edge");
	expo_bound_a: assert property (
		exposure_active |-> expo_len_reg < expo_cycles(2'h3))
		else $error("exposure window too long");
	one_frame_a: assert property (
		acq_start |=> !acq_start)
		else $error("free-running frame starts");
	addr_restore_a: assert property (
		ip_restore |=> net_address == `TSC_IP_DEFAULT && rs_reg == RS_WAIT)
		else $error("address not restored after hold");
	wait_off_a: assert property (
		rs_reg == RS_WAIT |=> !lamp_red && !lamp_green && !lamp_blue)
		else $error("lamp not off after restore hold");
	purple_lamp_a: assert property (
		rs_reg == RS_PURPLE |=> lamp_red && lamp_blue && !lamp_green)
		else $error("restore lamp not purple");
	conn_blue_a: assert property (
		rs_reg == RS_IDLE && pstate == PS_CONN |=>
		lamp_blue && !lamp_red && !lamp_green)
		else $error("connected lamp not steady blue");
	fw_white_a: assert property (
		rs_reg == RS_IDLE && pstate == PS_FW |=>
		lamp_red && lamp_green && lamp_blue)
		else $error("upgrade lamp not white");
	bcast_blink_a: assert property (
		rs_reg == RS_IDLE && pstate == PS_BCAST |=>
		lamp_blue == $past(phase_reg) && !lamp_green)
		else $error("broadcast lamp not blinking blue");
endmodule

// ### tb/tb_trigger_and_status_controller.sv
// Purpose: self-checking bench for the trigger and status controller
// Assumes: hold and purple counts shortened, blink divide set to 3
// Notes:   expected values come from a small model kept in the bench
`timescale 1ns/1ns
`include "tsc_defines.svh"

module tb_trigger_and_status_controller;
	import tsc_pkg::*;
	localparam int HOLD = 40;
	localparam int PURP = 20;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        pready, pslverr, acq_start, exposure_active;
	logic [31:0] prdata, net_address, rd;
	logic        lamp_red, lamp_green, lamp_blue, self_reset, err;
	logic        frame_trigger, busy;
	logic        restore_in = 1'b0;
	logic        button = 1'b0;
	logic        go = 1'b0;
	logic [15:0] width = 16'h03E8;
	logic [31:0] m_ip = `TSC_IP_DEFAULT;
	int n_mismatch = 0, checked = 0, cyc = 0, n_acq = 0, frames = 0;
	int run = 0, last_len = 0, d = 0, seed = 32'h6d3d;
	int er[4] = '{0, 0, 0, 16};
	int eg[4] = '{0, 0, 8, 16};
	int eb[4] = '{8, 16, 0, 16};
	int cr, cg, cb;
	time t_go, t_acq;

	always #50 pclk = ~pclk;

	tsc_top #(.HOLD_CYC(27'(HOLD)), .PURPLE_CYC(27'(PURP))) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .frame_trigger(frame_trigger),
		.address_restore_input(restore_in), .restore_button(button),
		.acq_start(acq_start), .exposure_active(exposure_active),
		.net_address(net_address), .lamp_red(lamp_red),
		.lamp_green(lamp_green), .lamp_blue(lamp_blue),
		.self_reset(self_reset));

	tsc_trig_src #(.GAP_CYC(5000)) SRC (
		.pclk(pclk), .go(go), .width(width), .trig(frame_trigger),
		.busy(busy));

	// --------------------------------------------------------------
	// monitor and timeout
	// --------------------------------------------------------------
	always @(posedge pclk) begin
		cyc++;
		if (acq_start === 1'b1) begin
			n_acq++;
			t_acq = $time;
		end
		if (exposure_active === 1'b1)
			run++;
		else if (run != 0) begin
			last_len = run;
			run = 0;
		end
		if (cyc == 50000) begin
			n_mismatch++;
			final_report;
		end
	end

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task automatic final_report;
		if (n_mismatch == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'(pready), 32'h1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("prdata", rd, e);
		chk("pslverr", 32'(err), 32'h0);
	endtask

	task automatic fire(input int w);
		int n;
		@(posedge pclk);
		width <= 16'(w);
		go    <= 1'b1;
		t_go = $time;
		@(posedge pclk);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (busy === 1'b1 && n < 9000);
		d = int'((t_acq - t_go) / 100);
	endtask

	task automatic hold(input logic use_btn);
		int n, pur, rises, sr;
		logic prev;
		@(posedge pclk);
		if (use_btn)
			button <= 1'b1;
		else
			restore_in <= 1'b1;
		repeat (HOLD + 20) @(posedge pclk);
		chk("net_address", net_address, `TSC_IP_DEFAULT);
		chk("lamp_off", {29'h0, lamp_red, lamp_green, lamp_blue}, 0);
		button     <= 1'b0;
		restore_in <= 1'b0;
		n = 0;
		pur = 0;
		rises = 0;
		sr = 0;
		prev = 1'b0;
		while (sr == 0 && n < 300) begin
			@(posedge pclk);
			n++;
			pur += int'((lamp_red & lamp_blue & ~lamp_green) === 1'b1);
			rises += int'(lamp_red === 1'b1 && prev !== 1'b1);
			prev = lamp_red;
			sr += int'(self_reset === 1'b1);
		end
		chk("purple", 32'(pur >= PURP), 32'h1);
		chk("flashes", 32'(rises == 3), 32'h1);
		chk("self_reset", 32'(sr), 32'h1);
		m_ip = `TSC_IP_DEFAULT;
		rdchk(`TSC_OFF_IPADDR, m_ip);
	endtask

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk("net_address", net_address, `TSC_IP_DEFAULT);
		rdchk(`TSC_OFF_CTRL, `TSC_CTRL_RST);
		rdchk(`TSC_OFF_IPADDR, `TSC_IP_DEFAULT);
		rdchk(`TSC_OFF_BLINK, {8'h00, `TSC_BLINK_RST});
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		chk("pslverr", 32'(err), 32'h1);
		apb(1'b0, 12'h010, 32'h0);
		chk("pslverr", 32'(err), 32'h1);
		chk("prdata", rd, 32'h0);
		apb(1'b1, `TSC_OFF_STATUS, 32'hFFFFFFFF);
		rdchk(`TSC_OFF_STATUS, 32'h0);
		apb(1'b1, `TSC_OFF_BLINK, 32'h3);
		m_ip = $random(seed);
		apb(1'b1, `TSC_OFF_IPADDR, m_ip);
		rdchk(`TSC_OFF_IPADDR, m_ip);
		chk("net_address", net_address, m_ip);
		fire(1000);
		chk("acq_count", 32'(n_acq), 32'h0);
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, `TSC_OFF_CTRL, {28'h0, 2'(r), 2'b01});
			fire(1000 + int'({$random(seed)} % 1000));
			frames++;
			chk("acq_count", 32'(n_acq), 32'(frames));
			chk("expo_len", 32'(last_len), 32'(1000 * (r + 1)));
			chk("acq_delay", 32'(d >= 3 && d <= 6), 32'h1);
		end
		rdchk(`TSC_OFF_STATUS, 32'(frames));
		apb(1'b1, `TSC_OFF_CTRL, 32'h3);
		fire(1500);
		frames++;
		chk("acq_count", 32'(n_acq), 32'(frames));
		chk("fall_delay", 32'(d >= 1503 && d <= 1506), 32'h1);
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, `TSC_OFF_CTRL, {26'h0, 2'(p), 4'h0});
			repeat (8) @(posedge pclk);
			cr = 0;
			cg = 0;
			cb = 0;
			repeat (16) begin
				@(posedge pclk);
				cr += int'(lamp_red === 1'b1);
				cg += int'(lamp_green === 1'b1);
				cb += int'(lamp_blue === 1'b1);
			end
			chk("lamp_red", 32'(cr), 32'(er[p]));
			chk("lamp_green", 32'(cg), 32'(eg[p]));
			chk("lamp_blue", 32'(cb), 32'(eb[p]));
		end
		apb(1'b1, `TSC_OFF_CTRL, 32'h10);
		m_ip = $random(seed);
		apb(1'b1, `TSC_OFF_IPADDR, m_ip);
		restore_in <= 1'b1;
		repeat (30) @(posedge pclk);
		restore_in <= 1'b0;
		repeat (10) @(posedge pclk);
		chk("net_address", net_address, m_ip);
		hold(1'b0);
		apb(1'b1, `TSC_OFF_IPADDR, 32'h0A0B0C0D);
		hold(1'b1);
		chk("acq_count", 32'(n_acq), 32'(frames));
		final_report;
	end
endmodule

// ### tb/tsc_trig_src.sv
// Purpose: model of the outside trigger source, a controller pin
// Assumes: one request on go starts one clean pulse of width cycles
// Notes:   the spacing is shortened so that the run stays short
`timescale 1ns/1ns

module tsc_trig_src #(
	parameter int GAP_CYC = 5000
) (
	input  wire logic        pclk,
	input  wire logic        go,
	input  wire logic [15:0] width,
	output logic             trig,
	output logic             busy
);
	int cnt = 0;

	// --------------------------------------------------------------
	// pulse generator
	// --------------------------------------------------------------
	// requests while busy are ignored, so spacing cannot be broken
	initial trig = 1'b0;
	initial busy = 1'b0;
	always @(posedge pclk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			trig <= 1'b1;
			cnt  <= 0;
		end else if (busy) begin
			cnt <= cnt + 1;
			if (cnt + 1 == int'(width))
				trig <= 1'b0;
			if (cnt + 1 == GAP_CYC)
				busy <= 1'b0;
		end
	end
endmodule
